//--- design/fss_sweep_sequencer.sv
// Frequency sweep sequencer with APB register file and GPIO lines
`timescale 1ns/1ps

module fss_sweep_sequencer #(
  parameter int FREQ_W = 32,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire  logic                            sys_clk,
  input  wire  logic                            rst,
  // APB slave
  input  wire  logic [fss_pkg::APB_AW-1:0]      paddr,
  input  wire  logic                            psel,
  input  wire  logic                            penable,
  input  wire  logic                            pwrite,
  input  wire  logic [fss_pkg::APB_DW-1:0]      pwdata,
  output       logic                            pready,
  output       logic [fss_pkg::APB_DW-1:0]      prdata,
  output       logic                            pslverr,
  // General-purpose lines
  input  wire  logic [fss_pkg::GPIO_N-1:0]      gpioIn,
  output       fss_pkg::fss_gpio_t              gpioPins,
  // Fractional modulator and divider side
  input  wire  logic [fss_pkg::GPIO_N-1:0]      fractionalModulatorOut,
  output       logic [FREQ_W-1:0]               divRatio,
  output       logic                            sweepBusy
);
  import fss_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic                 gpioEn_q;
  logic [DLY_W-1:0]     dly_q;
  logic [GCFG_W-1:0]    gcfg_q;
  logic                 trigSrc_q;
  logic                 dlyEn_q;
  logic [CTRL_W-1:0]    ctrl_q;
  logic [FREQ_W-1:0]    stepUp_q;
  logic [FREQ_W-1:0]    stepDn_q;
  logic [CNT_W-1:0]     stepNum_q;
  logic [FREQ_W-1:0]    start_q;
  logic [CNT_W-1:0]     stepPer_q;
  logic [CNT_W-1:0]     dwell_q;
  logic [APB_DW-1:0]    prdata_q;
  logic                 pslverr_q;
  logic [APB_DW-1:0]    rdNext;
  logic                 rdHit;
  logic [5:0]           regIdx;
  logic                 wrEn;
  logic                 spiTrig_q;
  logic [GPIO_N-1:0]    gpioSync1_q;
  logic [GPIO_N-1:0]    gpioSync2_q;
  logic                 trigPrev_q;
  logic                 extEdge;
  logic                 extOk;
  logic                 extTrig;
  logic                 dlyArmed;
  logic [DLY_W-1:0]     dlyCnt_q;
  logic                 dlyFire;
  logic                 trigNow;
  fss_state_t           state_q;
  logic [FREQ_W-1:0]    freq_q;
  logic                 dirUp_q;
  logic [CNT_W-1:0]     stepCnt_q;
  logic [CNT_W-1:0]     stepInc;
  logic [CNT_W-1:0]     tmr_q;
  logic                 sweepEn;
  fss_mode_t            mode;
  logic                 autoMode;
  logic                 oneWay;
  logic                 startUp;
  logic                 evt;
  logic                 stepTick;
  logic                 lastStep;
  logic                 rampSingle;
  logic                 rampGo;
  logic                 rampUp;
  logic [FREQ_W-1:0]    rampBase;
  logic                 hop;
  logic                 startFlag_q;
  logic                 stopFlag_q;
  logic                 ready;
  logic [GPIO_N-1:0]    gpioVal;
  fss_gpio_t            gpio_q;

  function automatic logic [FREQ_W-1:0] stepFreq(input logic [FREQ_W-1:0] f,
                                                 input logic              up,
                                                 input logic [FREQ_W-1:0] su,
                                                 input logic [FREQ_W-1:0] sd);
    stepFreq = up ? FREQ_W'(f + su) : FREQ_W'(f - sd);
  endfunction

  // ************************************************************
  // APB register file
  // ************************************************************
  assign regIdx  = paddr[7:2];
  assign wrEn    = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  assign pready  = 1'h1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpioEn_q  <= '0;
      dly_q     <= '0;
      gcfg_q    <= '0;
      trigSrc_q <= '0;
      dlyEn_q   <= '0;
      ctrl_q    <= RST_CTRL;
      stepUp_q  <= '0;
      stepDn_q  <= '0;
      stepNum_q <= CNT_W'(RST_STEP_NUM);
      start_q   <= '0;
      stepPer_q <= '0;
      dwell_q   <= '0;
    end else if (wrEn) begin
      case (regIdx)
        IDX_GPIO_EN:  gpioEn_q  <= pwdata[GPIO_EN_BIT];
        IDX_TRIG_DLY: dly_q     <= pwdata[DLY_W-1:0];
        IDX_GPIO_CFG: gcfg_q    <= pwdata[GCFG_W-1:0];
        IDX_SWP_TRIG: begin
          trigSrc_q <= pwdata[TRIG_SRC_BIT];
          dlyEn_q   <= pwdata[TRIG_DLYEN_BIT];
        end
        IDX_SWP_CTRL: ctrl_q    <= pwdata[CTRL_W-1:0];
        IDX_STEP_UP:  stepUp_q  <= pwdata[FREQ_W-1:0];
        IDX_STEP_DN:  stepDn_q  <= pwdata[FREQ_W-1:0];
        IDX_STEP_NUM: stepNum_q <= pwdata[CNT_W-1:0];
        IDX_START:    start_q   <= pwdata[FREQ_W-1:0];
        IDX_STEP_PER: stepPer_q <= pwdata[CNT_W-1:0];
        IDX_DWELL:    dwell_q   <= pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read word is captured in the setup cycle
  always_comb begin
    rdNext = '0;
    rdHit  = (paddr[1:0] == 2'h0);
    case (regIdx)
      IDX_GPIO_EN:  rdNext[GPIO_EN_BIT] = gpioEn_q;
      IDX_TRIG_DLY: rdNext[DLY_W-1:0] = dly_q;
      IDX_GPIO_CFG: rdNext[GCFG_W-1:0] = gcfg_q;
      IDX_SWP_TRIG: begin
        rdNext[TRIG_SRC_BIT]   = trigSrc_q;
        rdNext[TRIG_DLYEN_BIT] = dlyEn_q;
      end
      IDX_SWP_CTRL: rdNext[CTRL_W-1:0] = ctrl_q;
      IDX_STEP_UP:  rdNext[FREQ_W-1:0] = stepUp_q;
      IDX_STEP_DN:  rdNext[FREQ_W-1:0] = stepDn_q;
      IDX_STEP_NUM: rdNext[CNT_W-1:0] = stepNum_q;
      IDX_START:    rdNext[FREQ_W-1:0] = start_q;
      IDX_STEP_PER: rdNext[CNT_W-1:0] = stepPer_q;
      IDX_DWELL:    rdNext[CNT_W-1:0] = dwell_q;
      IDX_STATUS:   rdNext[STAT_W-1:0] = {2'(state_q), ready, sweepBusy};
      IDX_FREQ:     rdNext[FREQ_W-1:0] = freq_q;
      default:      rdHit = 1'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_q  <= '0;
      pslverr_q <= '0;
    end else if (psel & ~penable) begin
      prdata_q  <= rdNext;
      pslverr_q <= ~rdHit;
    end
  end

  // Serial trigger: one-cycle pulse, bit never stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spiTrig_q <= '0;
    end else begin
      spiTrig_q <= wrEn & (regIdx == IDX_SWP_TRIG) & pwdata[TRIG_SPI_BIT]
                   & ~pwdata[TRIG_SRC_BIT];
    end
  end

  // ************************************************************
  // External trigger path
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpioSync1_q <= '0;
      gpioSync2_q <= '0;
      trigPrev_q  <= '0;
    end else begin
      gpioSync1_q <= gpioIn;
      gpioSync2_q <= gpioSync1_q;
      trigPrev_q  <= gpioSync2_q[TRIG_LINE];
    end
  end

  assign extEdge  = gpioSync2_q[TRIG_LINE] & ~trigPrev_q;
  assign extOk    = trigSrc_q & ~gcfg_q[GDIR_LSB+TRIG_LINE] & gpioEn_q;
  assign extTrig  = extEdge & extOk;
  assign dlyArmed = dlyEn_q & (dly_q != '0);
  assign dlyFire  = (dlyCnt_q == DLY_W'(1));

  // Edges arriving while a delay runs are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dlyCnt_q <= '0;
    end else if (extTrig & dlyArmed & (dlyCnt_q == '0)) begin
      dlyCnt_q <= dly_q;
    end else if (dlyCnt_q != '0) begin
      dlyCnt_q <= DLY_W'(dlyCnt_q - 1'h1);
    end
  end

  assign trigNow = spiTrig_q | (extTrig & ~dlyArmed) | dlyFire;

  // ************************************************************
  // Sweep engine
  // ************************************************************
  assign sweepEn    = ctrl_q[CTRL_EN_BIT];
  assign mode       = fss_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign autoMode   = ctrl_q[CTRL_AUTO_BIT] & (mode != MODE_USER);
  assign oneWay     = (mode == MODE_ONE) | ((mode == MODE_USER) & ctrl_q[CTRL_UONE_BIT]);
  assign startUp    = ctrl_q[CTRL_UP_BIT];
  assign stepInc    = CNT_W'(stepCnt_q + 1'h1);
  assign lastStep   = stepInc >= stepNum_q;
  assign rampSingle = stepNum_q <= CNT_W'(1);

  // Internal triggers: at enable, from a hop left by triggered mode, after each dwell
  assign evt = autoMode ? ((state_q == ST_IDLE) | (state_q == ST_HOP) |
                           ((state_q == ST_HOLD) & (tmr_q == '0)))
                        : trigNow;

  assign stepTick = (state_q == ST_RAMP) &
                    ((mode == MODE_USER) ? trigNow : (tmr_q == '0));

  always_comb begin
    rampGo   = 1'h0;
    rampUp   = dirUp_q;
    rampBase = freq_q;
    hop      = 1'h0;
    unique case (state_q)
      ST_IDLE, ST_HOP: begin
        if (evt) begin
          rampGo   = 1'h1;
          rampUp   = startUp;
          rampBase = start_q;
        end
      end
      ST_HOLD: begin
        if (evt & oneWay & autoMode) begin
          rampGo   = 1'h1;
          rampUp   = startUp;
          rampBase = start_q;
        end else if (evt & oneWay) begin
          hop = 1'h1;
        end else if (evt) begin
          rampGo = 1'h1;
          rampUp = ~dirUp_q;
        end
      end
      ST_RAMP: ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (~sweepEn) begin
      state_q <= ST_IDLE;
    end else if (rampGo) begin
      state_q <= rampSingle ? ST_HOLD : ST_RAMP;
    end else if (hop) begin
      state_q <= ST_HOP;
    end else if (stepTick & lastStep) begin
      state_q <= ST_HOLD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      freq_q <= '0;
    end else if (~sweepEn) begin
      freq_q <= start_q;
    end else if (rampGo) begin
      freq_q <= stepFreq(rampBase, rampUp, stepUp_q, stepDn_q);
    end else if (hop) begin
      freq_q <= start_q;
    end else if (stepTick) begin
      freq_q <= stepFreq(freq_q, dirUp_q, stepUp_q, stepDn_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dirUp_q   <= '0;
      stepCnt_q <= '0;
    end else if (~sweepEn) begin
      dirUp_q   <= startUp;
      stepCnt_q <= '0;
    end else if (rampGo) begin
      dirUp_q   <= rampUp;
      stepCnt_q <= CNT_W'(1);
    end else if (stepTick) begin
      stepCnt_q <= stepInc;
    end
  end

  // Step interval while ramping, dwell while holding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmr_q <= '0;
    end else if (rampGo) begin
      tmr_q <= rampSingle ? dwell_q : stepPer_q;
    end else if (stepTick) begin
      tmr_q <= lastStep ? dwell_q : stepPer_q;
    end else if (tmr_q != '0) begin
      tmr_q <= CNT_W'(tmr_q - 1'h1);
    end
  end

  // ************************************************************
  // Status flags and outputs
  // ************************************************************
  assign sweepBusy = (state_q == ST_RAMP);
  assign ready     = sweepEn & (state_q != ST_RAMP);
  assign divRatio  = freq_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      startFlag_q <= '0;
      stopFlag_q  <= '0;
    end else begin
      startFlag_q <= rampGo;
      stopFlag_q  <= (stepTick & lastStep) | (rampGo & rampSingle);
    end
  end

  always_comb begin
    unique case (gcfg_q[GSEL_LSB +: 4])
      GSEL_TEST:  gpioVal = gcfg_q[GTEST_LSB +: GPIO_N];
      GSEL_MOD:   gpioVal = fractionalModulatorOut;
      GSEL_SWEEP: gpioVal = {ready, startFlag_q, stopFlag_q, sweepBusy, 1'h0};
      default:    gpioVal = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_q <= '0;
    end else begin
      gpio_q.out <= gpioVal;
      gpio_q.oe  <= gpioEn_q ? gcfg_q[GDIR_LSB +: GPIO_N] : '0;
    end
  end

  assign gpioPins = gpio_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_gpio_release: assert property (!gpioEn_q |=> gpioPins.oe == '0)
    else $error("gpio lines driven while master enable is low");
  a_busy_line: assert property ((gcfg_q[3:0] == GSEL_SWEEP) |=> gpioPins.out[1] == $past(sweepBusy))
    else $error("line one does not follow busy flag");
  a_spi_trigger: assert property (wrEn && regIdx == IDX_SWP_TRIG && pwdata[12] && !pwdata[13]
                                 |=> trigNow)
    else $error("serial trigger write did not fire");
  a_ext_gating: assert property (extEdge && !extOk && !spiTrig_q && dlyCnt_q == '0 |-> !trigNow)
    else $error("external edge taken while line four is not a trigger");
  a_delay_one: assert property (extTrig && dlyEn_q && dly_q == 21'h1 && dlyCnt_q == '0 |=> trigNow)
    else $error("delay of one period not applied at next edge");
  a_delay_three: assert property (extTrig && dlyEn_q && dly_q == 21'h3 && dlyCnt_q == '0
                                 |=> !dlyFire ##1 !dlyFire ##1 dlyFire)
    else $error("delay of three periods misplaced");
  a_nodelay_now: assert property (extTrig && !dlyEn_q |-> trigNow)
    else $error("undelayed trigger not applied at once");
  a_step_up: assert property (sweepEn && stepTick && dirUp_q
                             |=> freq_q == FREQ_W'($past(freq_q) + $past(stepUp_q)))
    else $error("rising step size wrong");
  a_first_dir: assert property (sweepEn && state_q == ST_IDLE && rampGo |=> dirUp_q == $past(startUp))
    else $error("first ramp direction wrong");
  a_twoway_flip: assert property (sweepEn && state_q == ST_HOLD && evt && !oneWay
                                 |=> dirUp_q != $past(dirUp_q))
    else $error("two-way ramp did not reverse");
  a_oneway_hop: assert property (sweepEn && state_q == ST_HOLD && evt && oneWay && !autoMode
                                |=> state_q == ST_HOP && freq_q == $past(start_q))
    else $error("one-way hop to start missing");
  a_hold_steady: assert property (sweepEn && state_q == ST_HOLD && !evt && $stable(sweepEn)
                                 |=> $stable(freq_q))
    else $error("held word changed without an event");

  c_twoway_flip: cover property (state_q == ST_HOLD && evt && !oneWay);
  c_oneway_hop: cover property (state_q == ST_HOP && evt);
  c_delay_fire: cover property (dlyFire && extOk);
  c_user_step: cover property (mode == MODE_USER && stepTick);

endmodule

//--- design/fss_pkg.sv
// Shared constants and types of the frequency sweep sequencer
package fss_pkg;

  // ************************************************************
  // Bus and register indices (byte address = index * 4)
  // ************************************************************
  localparam int         APB_AW       = 8;
  localparam int         APB_DW       = 32;
  localparam logic [5:0] IDX_GPIO_EN  = 6'h01;
  localparam logic [5:0] IDX_TRIG_DLY = 6'h05;
  localparam logic [5:0] IDX_GPIO_CFG = 6'h08;
  localparam logic [5:0] IDX_SWP_TRIG = 6'h0e;
  localparam logic [5:0] IDX_SWP_CTRL = 6'h10;
  localparam logic [5:0] IDX_STEP_UP  = 6'h11;
  localparam logic [5:0] IDX_STEP_DN  = 6'h12;
  localparam logic [5:0] IDX_STEP_NUM = 6'h13;
  localparam logic [5:0] IDX_START    = 6'h14;
  localparam logic [5:0] IDX_STEP_PER = 6'h15;
  localparam logic [5:0] IDX_DWELL    = 6'h16;
  localparam logic [5:0] IDX_STATUS   = 6'h17;
  localparam logic [5:0] IDX_FREQ     = 6'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int GPIO_N         = 5;
  localparam int GPIO_EN_BIT    = 4;
  localparam int DLY_W          = 21;
  localparam int GCFG_W         = 14;
  localparam int GSEL_LSB       = 0;
  localparam int GTEST_LSB      = 4;
  localparam int GDIR_LSB       = 9;
  localparam int TRIG_DLYEN_BIT = 7;
  localparam int TRIG_SPI_BIT   = 12;
  localparam int TRIG_SRC_BIT   = 13;
  localparam int TRIG_LINE      = 4;
  localparam int CTRL_W         = 6;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_AUTO_BIT  = 3;
  localparam int CTRL_UP_BIT    = 4;
  localparam int CTRL_UONE_BIT  = 5;
  localparam int STAT_W         = 4;

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [3:0] GSEL_TEST    = 4'h0;
  localparam logic [3:0] GSEL_MOD     = 4'h2;
  localparam logic [3:0] GSEL_SWEEP   = 4'h8;
  localparam logic [CTRL_W-1:0] RST_CTRL = 6'h00;
  localparam int         RST_STEP_NUM = 1;

  typedef enum logic [1:0] {MODE_TWO, MODE_ONE, MODE_USER, MODE_RSVD} fss_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD, ST_HOP} fss_state_t;

  typedef struct packed {
    logic [GPIO_N-1:0] out;
    logic [GPIO_N-1:0] oe;
  } fss_gpio_t;

endpackage

//--- tb/fss_trig_src.sv
// Far-side model: external trigger source and modulator stream
`timescale 1ns/1ps

module fss_trig_src #(
  parameter int SETTLE = 8
) (
  // Clock and request from the bench
  input  wire logic       sys_clk,
  input  wire logic       fire,
  // Lines toward the block
  output      logic [4:0] lines  = 5'h00,
  output      logic [4:0] modOut = 5'h00
);
  int hold  = 0;
  int quiet = 0;

  // ************************************************************
  // Line four pulse, low lines never still
  // ************************************************************
  always @(posedge sys_clk) begin
    modOut <= modOut + 5'h01;
    lines  <= {hold > 0, ~modOut[3:0]};
    if (fire && quiet == 0) begin
      hold  <= 4;
      quiet <= SETTLE;
    end else begin
      hold  <= (hold > 0) ? hold - 1 : 0;
      quiet <= (quiet > 0) ? quiet - 1 : 0;
    end
  end
endmodule

//--- tb/fss_sweep_sequencer_tb.sv
// Self-checking bench of the sweep sequencer
`timescale 1ns/1ps

module fss_sweep_sequencer_tb;
  import fss_pkg::*;

  logic              sys_clk   = 1'b0;
  logic              rst       = 1'b1;
  logic [APB_AW-1:0] paddr     = '0;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [APB_DW-1:0] pwdata    = '0;
  logic              pready;
  logic [APB_DW-1:0] prdata;
  logic              pslverr;
  logic [4:0]        gpioIn;
  logic [4:0]        modOut;
  fss_gpio_t         gpioPins;
  logic [31:0]       divRatio;
  logic              sweepBusy;
  logic              fire      = 1'b0;
  logic [32:0]       notes[$];
  int                err_total = 0;
  int                num_checks = 0;
  int                cyc       = 0;
  logic [31:0]       seed      = 32'h4c;
  logic [31:0]       s;
  logic [31:0]       u;
  logic [31:0]       d;

  always #12.5 sys_clk = ~sys_clk;

  fss_sweep_sequencer dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .gpioIn(gpioIn), .gpioPins(gpioPins),
    .fractionalModulatorOut(modOut), .divRatio(divRatio), .sweepBusy(sweepBusy));
  fss_trig_src src (.sys_clk(sys_clk), .fire(fire), .lines(gpioIn), .modOut(modOut));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic apb(logic [5:0] idx, logic wr, logic [31:0] wd);
    int n = 0;
    @(posedge sys_clk);
    paddr   <= {idx, 2'b00};
    pwrite  <= wr;
    pwdata  <= wd;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [5:0] idx, logic [31:0] wd);
    apb(idx, 1'b1, wd);
  endtask

  task automatic rd(logic [5:0] idx, logic [31:0] exp, logic err);
    notes.push_back({err, exp});
    apb(idx, 1'b0, 32'h0);
  endtask

  task automatic waitBusy(logic lvl, output int n);
    n = 0;
    while (sweepBusy !== lvl && n < 60) begin
      tick();
      n++;
    end
  endtask

  task automatic ramp(logic [31:0] first);
    int n;
    waitBusy(1'b1, n);
    check("busy rise", {32'h0, sweepBusy}, 33'h1);
    check("first step", {1'b0, divRatio}, {1'b0, first});
    waitBusy(1'b0, n);
    check("busy length", 33'(n), 33'h2);
  endtask

  task automatic ext(output int n);
    int m;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    waitBusy(1'b1, n);
    if (n < 60) begin
      tick();
      check("flag line", {31'h0, gpioPins.oe[1], gpioPins.out[1]}, 33'h3);
      waitBusy(1'b0, m);
    end
  endtask

  // ************************************************************
  // Read monitor and timeout
  // ************************************************************
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite)
      check($sformatf("reg %h", paddr), {pslverr, prdata}, notes.pop_front());
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    int n;
    int t0;
    s = (rnd() & 32'hffff) + 32'h1000;
    u = (rnd() & 32'hff) + 32'h1;
    d = (rnd() & 32'hff) + 32'h1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_STEP_NUM, 32'h1, 1'b0);
    rd(IDX_SWP_TRIG, 32'h0, 1'b0);
    rd(6'h3f, 32'h0, 1'b1);
    wr(IDX_START, s);
    wr(IDX_STEP_UP, u);
    wr(IDX_STEP_DN, d);
    wr(IDX_STEP_NUM, 32'h3);
    $display("test registers done");
    for (int up = 1; up >= 0; up--) begin
      wr(IDX_SWP_CTRL, up ? 32'h11 : 32'h01);
      wr(IDX_SWP_TRIG, 32'h1000);
      ramp(up ? s + u : s - d);
      repeat (20) tick();
      rd(IDX_FREQ, up ? s + 3 * u : s - 3 * d, 1'b0);
      wr(IDX_SWP_TRIG, 32'h1000);
      ramp(up ? s + 3 * u - d : s - 3 * d + u);
      wr(IDX_SWP_CTRL, 32'h0);
    end
    $display("test two-way done");
    wr(IDX_SWP_CTRL, 32'h13);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_SWP_TRIG, 32'h1000);
      ramp(s + u);
      wr(IDX_SWP_TRIG, 32'h1000);
      repeat (4) tick();
      rd(IDX_FREQ, s, 1'b0);
    end
    wr(IDX_SWP_CTRL, 32'h19);
    ramp(s + u);
    wr(IDX_SWP_CTRL, 32'h0);
    $display("test one-way and auto done");
    wr(IDX_SWP_CTRL, 32'h35);
    for (int i = 1; i <= 5; i++) begin
      wr(IDX_SWP_TRIG, 32'h1000);
      repeat (4) tick();
      rd(IDX_FREQ, i <= 3 ? s + i * u : (i == 4 ? s : s + u), 1'b0);
    end
    wr(IDX_SWP_CTRL, 32'h0);
    $display("test user done");
    wr(IDX_GPIO_EN, 32'h10);
    wr(IDX_GPIO_CFG, 32'h1e08);
    wr(IDX_TRIG_DLY, 32'h6);
    wr(IDX_SWP_TRIG, 32'h2080);
    wr(IDX_SWP_CTRL, 32'h11);
    ext(t0);
    wr(IDX_TRIG_DLY, 32'h2);
    ext(n);
    check("delay span", 33'(t0 - n), 33'h4);
    wr(IDX_GPIO_EN, 32'h0);
    ext(n);
    check("gated trigger", 33'(n), 33'd60);
    check("lines released", {28'h0, gpioPins.oe}, 33'h0);
    wr(IDX_GPIO_EN, 32'h10);
    wr(IDX_GPIO_CFG, 32'h1f50);
    repeat (2) tick();
    check("test lines", {23'h0, gpioPins.oe, gpioPins.out}, 33'h1f5);
    $display("test external done");
    results();
  end
endmodule
